// File: common/cws_defines.svh
// offsets, field positions, reset values and counts for the cpu clock select block
`ifndef CWS_DEFINES_SVH
`define CWS_DEFINES_SVH

// register indices on the plain register port
`define CWS_CONFIG_ADDR 4'h0
`define CWS_STATUS_ADDR 4'h1
`define CWS_MASK_ADDR 4'h2
`define CWS_CLKSTAT_ADDR 4'h3

// field positions
`define CWS_WD_DISABLE_BIT 4
`define CWS_FAIL_BIT 0
`define CWS_STAT_FAIL_BIT 3
`define CWS_STAT_PLL_BIT 4
`define CWS_STAT_WD_BIT 5

// reset values
`define CWS_CONFIG_RST 16'h0000
`define CWS_STATUS_RST 16'h0000
`define CWS_MASK_RST 16'h0000
`define CWS_HP_INIT 8'h04

// counts
`define CWS_WD_LIMIT 5'h10
`define CWS_FREE_DIV 8'h04
`define CWS_HP_MIN 8'h01

`endif

// File: common/cws_pkg.sv
// types for the cpu clock select block
package cws_pkg;

  typedef enum logic [2:0] {
    CWS_X2P5 = 3'b000,
    CWS_PRESCALE = 3'b001,
    CWS_X1P5 = 3'b010,
    CWS_DIRECT = 3'b011,
    CWS_X5 = 3'b100,
    CWS_X2 = 3'b101,
    CWS_X3 = 3'b110,
    CWS_X4 = 3'b111
  } cws_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cws_bus_req_s;

  typedef struct packed {
    logic [3:0] sync_trans;
    logic [4:0] expect_hp;
  } cws_pll_cfg_s;

endpackage

// File: src/cws_osc_watchdog.sv
// oscillator watchdog counter
`timescale 1ns/10ps
`include "cws_defines.svh"
module cws_osc_watchdog (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic enable,
  input wire logic pll_tick,
  input wire logic osc_edge,
  // result
  output logic overflow
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic ovf_q;
  logic ovf_d;

  always_comb
  begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (!enable)
    begin
      cnt_d = 5'h00;
    end
    else if (osc_edge)
    begin
      cnt_d = 5'h00;
    end
    else if (pll_tick)
    begin
      if (cnt_q == `CWS_WD_LIMIT - 5'h01)
      begin
        cnt_d = 5'h00;
        ovf_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt_q <= 5'h00;
      ovf_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign overflow = ovf_q;

endmodule // cws_osc_watchdog

// File: src/cws_pll_gen.sv
// pll half-period generator with gradual lock to the input clock
`timescale 1ns/10ps
`include "cws_defines.svh"
module cws_pll_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic enable,
  input wire logic osc_edge,
  input wire cws_pkg::cws_pll_cfg_s cfg,
  // half-period pulse
  output logic hp_tick
);

  logic [7:0] len_q;
  logic [7:0] len_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [3:0] trans_q;
  logic [3:0] trans_d;
  logic [5:0] seen_q;
  logic [5:0] seen_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    len_d = len_q;
    cnt_d = cnt_q;
    trans_d = trans_q;
    seen_d = seen_q;
    tick_d = 1'b0;
    if (enable)
    begin
      if (cnt_q + 8'h01 >= len_q)
      begin
        cnt_d = 8'h00;
        tick_d = 1'b1;
        seen_d = seen_q + 6'h01;
      end
      else
      begin
        cnt_d = cnt_q + 8'h01;
      end
      if (osc_edge)
      begin
        if (trans_q + 4'h1 >= cfg.sync_trans)
        begin
          trans_d = 4'h0;
          seen_d = 6'h00;
          if (seen_q < {1'b0, cfg.expect_hp} && len_q > `CWS_HP_MIN)
          begin
            len_d = len_q - 8'h01;
          end
          else if (seen_q > {1'b0, cfg.expect_hp} && len_q != 8'hFF)
          begin
            len_d = len_q + 8'h01;
          end
        end
        else
        begin
          trans_d = trans_q + 4'h1;
        end
      end
    end
    else
    begin
      cnt_d = 8'h00;
      trans_d = 4'h0;
      seen_d = 6'h00;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      len_q <= `CWS_HP_INIT;
      cnt_q <= 8'h00;
      trans_q <= 4'h0;
      seen_q <= 6'h00;
      tick_q <= 1'b0;
    end
    else if (clk_en)
    begin
      len_q <= len_d;
      cnt_q <= cnt_d;
      trans_q <= trans_d;
      seen_q <= seen_d;
      tick_q <= tick_d;
    end
  end

  assign hp_tick = tick_q;

endmodule // cws_pll_gen

// File: src/cws_clock_select.sv
// cpu clock select with oscillator watchdog, top level
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "cws_defines.svh"
module cws_clock_select #(
  parameter logic [7:0] FREE_DIV = `CWS_FREE_DIV
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // external clock and straps
  input wire logic osc_input_pin,
  input wire logic [2:0] clock_mode_pins,
  // register port
  input wire cws_pkg::cws_bus_req_s bus_req,
  output logic [15:0] rd_data,
  // clock outputs
  output logic cpu_clk,
  output logic clock_half_period,
  output logic pll_enable,
  // interrupt
  output logic osc_fail_irq
);

  // mode helpers
  function automatic logic is_wd_mode(input cws_pkg::cws_mode_e m);
    is_wd_mode = (m == cws_pkg::CWS_DIRECT) || (m == cws_pkg::CWS_PRESCALE);
  endfunction

  function automatic cws_pkg::cws_pll_cfg_s pll_cfg(input cws_pkg::cws_mode_e m);
    cws_pkg::cws_pll_cfg_s c;
    c.sync_trans = 4'h2;
    c.expect_hp = 5'h02;
    case (m)
      cws_pkg::CWS_X4:
      begin
        c.sync_trans = 4'h4;
        c.expect_hp = 5'h10;
      end
      cws_pkg::CWS_X3:
      begin
        c.sync_trans = 4'h3;
        c.expect_hp = 5'h09;
      end
      cws_pkg::CWS_X2:
      begin
        c.sync_trans = 4'h2;
        c.expect_hp = 5'h04;
      end
      cws_pkg::CWS_X5:
      begin
        c.sync_trans = 4'h5;
        c.expect_hp = 5'h19;
      end
      cws_pkg::CWS_X1P5:
      begin
        c.sync_trans = 4'h6;
        c.expect_hp = 5'h09;
      end
      cws_pkg::CWS_X2P5:
      begin
        c.sync_trans = 4'hA;
        c.expect_hp = 5'h19;
      end
      default:
      begin
        c.sync_trans = 4'h2;
        c.expect_hp = 5'h02;
      end
    endcase
    pll_cfg = c;
  endfunction

  // mode latch
  cws_pkg::cws_mode_e mode_q;
  cws_pkg::cws_mode_e mode_d;

  always_comb
  begin
    mode_d = mode_q;
    if (reset)
    begin
      mode_d = cws_pkg::cws_mode_e'(clock_mode_pins);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    mode_q <= mode_d;
  end

  // oscillator input edges
  logic osc_q;
  logic osc_d;
  logic osc_edge;
  logic osc_rise;

  always_comb
  begin
    osc_d = osc_input_pin;
    osc_edge = osc_input_pin ^ osc_q;
    osc_rise = osc_input_pin & ~osc_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      osc_q <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_q <= osc_d;
    end
  end

  // register state
  logic [15:0] config_q;
  logic [15:0] config_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic irq_q;
  logic irq_d;

  // clock state
  logic fail_q;
  logic fail_d;
  logic cpu_clk_q;
  logic cpu_clk_d;
  logic hp_q;
  logic hp_d;
  logic pll_en_q;
  logic pll_en_d;
  logic [7:0] fr_cnt_q;
  logic [7:0] fr_cnt_d;
  logic fr_tick;

  logic wd_mode;
  logic wd_on;
  logic wd_ovf;
  logic pll_mode;
  logic pll_tick;
  logic src_tick;
  cws_pkg::cws_pll_cfg_s cfg;

  always_comb
  begin
    wd_mode = is_wd_mode(mode_q);
    pll_mode = !is_wd_mode(mode_q);
    wd_on = wd_mode && !config_q[`CWS_WD_DISABLE_BIT] && !fail_q;
    cfg = pll_cfg(mode_q);
  end

  // free-running pll clock
  always_comb
  begin
    fr_cnt_d = fr_cnt_q;
    fr_tick = 1'b0;
    if (wd_on || fail_q)
    begin
      if (fr_cnt_q + 8'h01 >= FREE_DIV)
      begin
        fr_cnt_d = 8'h00;
        fr_tick = 1'b1;
      end
      else
      begin
        fr_cnt_d = fr_cnt_q + 8'h01;
      end
    end
    else
    begin
      fr_cnt_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fr_cnt_q <= 8'h00;
    end
    else if (clk_en)
    begin
      fr_cnt_q <= fr_cnt_d;
    end
  end

  cws_osc_watchdog u_watchdog (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .enable(wd_on),
    .pll_tick(fr_tick),
    .osc_edge(osc_edge),
    .overflow(wd_ovf)
  );

  cws_pll_gen u_pll (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .enable(pll_mode),
    .osc_edge(osc_edge),
    .cfg(cfg),
    .hp_tick(pll_tick)
  );

  // cpu clock source selection
  always_comb
  begin
    fail_d = fail_q | wd_ovf;
    pll_en_d = pll_mode || wd_on || fail_d;
    cpu_clk_d = cpu_clk_q;
    src_tick = 1'b0;
    if (fail_q)
    begin
      src_tick = fr_tick;
    end
    else if (mode_q == cws_pkg::CWS_DIRECT)
    begin
      src_tick = osc_edge;
    end
    else if (mode_q == cws_pkg::CWS_PRESCALE)
    begin
      src_tick = osc_rise;
    end
    else
    begin
      src_tick = pll_tick;
    end
    if (!fail_q && mode_q == cws_pkg::CWS_DIRECT)
    begin
      cpu_clk_d = osc_input_pin;
    end
    else if (src_tick)
    begin
      cpu_clk_d = !cpu_clk_q;
    end
    hp_d = src_tick;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fail_q <= 1'b0;
      cpu_clk_q <= 1'b0;
      hp_q <= 1'b0;
      pll_en_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fail_q <= fail_d;
      cpu_clk_q <= cpu_clk_d;
      hp_q <= hp_d;
      pll_en_q <= pll_en_d;
    end
  end

  // register port
  always_comb
  begin
    config_d = config_q;
    status_d = status_q;
    mask_d = mask_q;
    rdata_d = 16'h0000;
    if (bus_req.wr)
    begin
      if (bus_req.addr == `CWS_CONFIG_ADDR)
      begin
        config_d = bus_req.wdata;
      end
      else if (bus_req.addr == `CWS_STATUS_ADDR)
      begin
        status_d = status_q & ~bus_req.wdata;
      end
      else if (bus_req.addr == `CWS_MASK_ADDR)
      begin
        mask_d = bus_req.wdata;
      end
    end
    if (wd_ovf)
    begin
      status_d[`CWS_FAIL_BIT] = 1'b1;
    end
    if (bus_req.rd)
    begin
      if (bus_req.addr == `CWS_CONFIG_ADDR)
      begin
        rdata_d = config_q;
      end
      else if (bus_req.addr == `CWS_STATUS_ADDR)
      begin
        rdata_d = status_q;
      end
      else if (bus_req.addr == `CWS_MASK_ADDR)
      begin
        rdata_d = mask_q;
      end
      else if (bus_req.addr == `CWS_CLKSTAT_ADDR)
      begin
        rdata_d[2:0] = mode_q;
        rdata_d[`CWS_STAT_FAIL_BIT] = fail_q;
        rdata_d[`CWS_STAT_PLL_BIT] = pll_en_q;
        rdata_d[`CWS_STAT_WD_BIT] = wd_on;
      end
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      config_q <= `CWS_CONFIG_RST;
      status_q <= `CWS_STATUS_RST;
      mask_q <= `CWS_MASK_RST;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      config_q <= config_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign rd_data = rdata_q;
  assign cpu_clk = cpu_clk_q;
  assign clock_half_period = hp_q;
  assign pll_enable = pll_en_q;
  assign osc_fail_irq = irq_q;

endmodule // cws_clock_select

// File: tb/cws_osc_model.sv
// external oscillator model driving the clock input pin
`timescale 1ns/10ps
module cws_osc_model (
  // clock
  input wire logic sys_clk,
  // control
  input wire logic run,
  input wire logic [7:0] half,
  // external clock
  output logic osc
);
  logic [7:0] cnt_q;
  initial
  begin
    osc = 1'b0;
    cnt_q = 8'h00;
  end
  // a stopped source holds its last level
  always @(posedge sys_clk)
    if (run)
    begin
      cnt_q <= (cnt_q + 8'h01 >= half) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q + 8'h01 >= half)
        osc <= ~osc;
    end
endmodule // cws_osc_model

// File: tb/cws_clock_select_assertions.sv
// assertion checker for the cpu clock select block
`timescale 1ns/10ps
`include "cws_defines.svh"
module cws_clock_select_checker #(
  parameter logic [7:0] FREE_DIV = `CWS_FREE_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // pins
  input wire logic osc_input_pin,
  input wire logic [2:0] clock_mode_pins,
  // register port
  input wire cws_pkg::cws_bus_req_s bus_req,
  input wire logic [15:0] rd_data,
  // outputs
  input wire logic cpu_clk,
  input wire logic clock_half_period,
  input wire logic pll_enable,
  input wire logic osc_fail_irq
);
  logic [2:0] mode_q;
  logic [7:0] idle_q;
  logic mask_q, wd_dis_q, seen_q, last_q, wd_mode;
  // mirrors of strap, mask, disable bit and input idle time
  always_ff @(posedge sys_clk)
  begin
    last_q <= osc_input_pin;
    if (reset)
    begin
      mode_q <= clock_mode_pins;
      idle_q <= 8'h00;
      mask_q <= 1'b0;
      wd_dis_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      idle_q <= (osc_input_pin != last_q) ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
      if (bus_req.wr && bus_req.addr == `CWS_MASK_ADDR)
        mask_q <= bus_req.wdata[0];
      if (bus_req.wr && bus_req.addr == `CWS_CONFIG_ADDR)
        wd_dis_q <= bus_req.wdata[4];
      seen_q <= seen_q | osc_fail_irq;
    end
  end
  assign wd_mode = mode_q == cws_pkg::CWS_DIRECT || mode_q == cws_pkg::CWS_PRESCALE;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_pin_rise;
    mode_q == cws_pkg::CWS_PRESCALE && !seen_q && $rose(osc_input_pin)
    && !$past(reset) && !$past(reset, 2);
  endsequence
  a_prescale_toggle: assert property (s_pin_rise |-> ##[1:3] $changed(cpu_clk))
    else $error("prescaled clock missed an input rise");
  a_direct_follow: assert property (
    mode_q == cws_pkg::CWS_DIRECT && !seen_q && idle_q < 8'h14 && !$past(reset)
    |-> cpu_clk == $past(osc_input_pin)) else $error("cpu clock not following input");
  a_pll_mode_on: assert property (!wd_mode && !$past(reset) |-> pll_enable)
    else $error("pll off in a multiply mode");
  a_wd_default_on: assert property ($fell(reset) |=> pll_enable)
    else $error("pll not running after reset");
  a_wd_off_pll: assert property (
    wd_mode && wd_dis_q && $past(wd_dis_q, 2) && !seen_q |-> !pll_enable)
    else $error("pll running with watchdog disabled");
  a_fail_window: assert property (
    $rose(osc_fail_irq) && mask_q && $past(mask_q)
    |-> idle_q >= 15 * FREE_DIV && idle_q <= 16 * FREE_DIV + 8)
    else $error("failure flagged at wrong idle time");
  a_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !osc_fail_irq)
    else $error("interrupt high while masked");
  a_read_pulse: assert property (rd_data != 16'h0000 |-> $past(bus_req.rd))
    else $error("read data outside the read answer cycle");
  a_half_tick: assert property (
    !$past(reset) |-> clock_half_period == $changed(cpu_clk))
    else $error("half-period pulse out of step with cpu clock");
endmodule // cws_clock_select_checker
bind cws_clock_select cws_clock_select_checker #(.FREE_DIV(FREE_DIV)) i_cws_clock_select_checker (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .osc_input_pin(osc_input_pin),
  .clock_mode_pins(clock_mode_pins), .bus_req(bus_req), .rd_data(rd_data), .cpu_clk(cpu_clk),
  .clock_half_period(clock_half_period), .pll_enable(pll_enable), .osc_fail_irq(osc_fail_irq));

// File: tb/cws_clock_select_test.sv
// self-checking bench for the cpu clock select block
`timescale 1ns/10ps
`include "cws_defines.svh"
module cws_clock_select_test;
  logic sys_clk, reset, clk_en, osc_input_pin, cpu_clk, clock_half_period;
  logic pll_enable, osc_fail_irq, osc_run;
  logic [2:0] clock_mode_pins;
  logic [15:0] rd_data, rv, rnd;
  logic [7:0] osc_half;
  cws_pkg::cws_bus_req_s bus_req;
  int miscompares, checks, n, e;
  cws_clock_select #(.FREE_DIV(8'h02)) i_cws_clock_select (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .osc_input_pin(osc_input_pin), .clock_mode_pins(clock_mode_pins),
    .bus_req(bus_req), .rd_data(rd_data), .cpu_clk(cpu_clk),
    .clock_half_period(clock_half_period), .pll_enable(pll_enable), .osc_fail_irq(osc_fail_irq));
  cws_osc_model i_cws_osc_model (.sys_clk(sys_clk), .run(osc_run), .half(osc_half),
    .osc(osc_input_pin));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int tol);
    chk(16'(n + tol >= e && n <= e + tol), 16'h0001);
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // cpu half-periods expected for a number of input transitions
  function automatic int exp_hp(input logic [2:0] m, input int tr);
    int f10[8] = '{25, 5, 15, 10, 50, 20, 30, 40};
    return tr * f10[m] / 10;
  endfunction
  task automatic do_reset(input logic [2:0] mode);
    osc_run <= 1'b1;
    clock_mode_pins <= mode;
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    clock_mode_pins <= 3'($urandom);
    reset <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
    @(posedge sys_clk);
  endtask
  task automatic count_hp(input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(posedge sys_clk);
      n += int'(clock_half_period === 1'b1);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    bus_req = '0;
    osc_run = 1'b0;
    osc_half = 8'h14;
    clock_mode_pins = 3'h7;
    void'($urandom(32'h7705));
    for (int m = 0; m < 8; m++)
    begin
      do_reset(3'(m));
      repeat (1600) @(posedge sys_clk);
      count_hp(1200);
      e = exp_hp(3'(m), 60);
      near(e / 8 + 2);
      rd(`CWS_CLKSTAT_ADDR, rv);
      chk(rv, {10'h000, m == 1 || m == 3, 1'b1, 1'b0, 3'(m)});
      $display("mode %0d test done", m);
    end
    osc_half = 8'(8 + $urandom % 8);
    do_reset(3'b011);
    wr(`CWS_MASK_ADDR, 16'h0001);
    osc_run <= 1'b0;
    n = 0;
    while (osc_fail_irq !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 100)
    begin
      miscompares++;
      summarize;
    end
    e = 2 * int'(`CWS_WD_LIMIT);
    chk(16'(n + int'(osc_half) >= e && n <= e + 4), 16'h0001);
    rd(`CWS_STATUS_ADDR, rv);
    chk(rv, 16'h0001);
    rd(`CWS_CLKSTAT_ADDR, rv);
    chk(rv, 16'h001B);
    osc_run <= 1'b1;
    count_hp(200);
    e = 100;
    near(2);
    chk(osc_fail_irq, 1'b1);
    wr(`CWS_STATUS_ADDR, 16'h0001);
    chk(osc_fail_irq, 1'b0);
    $display("watchdog failure test done");
    do_reset(3'b001);
    rd(`CWS_CLKSTAT_ADDR, rv);
    chk(rv, 16'h0031);
    osc_run <= 1'b0;
    repeat (100) @(posedge sys_clk);
    chk(osc_fail_irq, 1'b0);
    rd(`CWS_STATUS_ADDR, rv);
    chk(rv, 16'h0001);
    count_hp(100);
    e = 50;
    near(2);
    $display("masked failure test done");
    do_reset(3'b001);
    repeat (3)
    begin
      rnd = 16'($urandom);
      wr(`CWS_CONFIG_ADDR, rnd);
      rd(`CWS_CONFIG_ADDR, rv);
      chk(rv, rnd);
      rd(4'(4 + $urandom % 12), rv);
      chk(rv, 16'h0000);
    end
    wr(`CWS_CONFIG_ADDR, 16'h0010);
    rd(`CWS_CLKSTAT_ADDR, rv);
    chk(rv, 16'h0001);
    chk(pll_enable, 1'b0);
    osc_run <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rd(`CWS_STATUS_ADDR, rv);
    chk(rv, 16'h0000);
    $display("watchdog disable test done");
    summarize;
  end
endmodule // cws_clock_select_test
